// [include/ccs_params.svh]
// register map, field positions, reset values and limits of clock check
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

`define CCS_ADDR_W 12
`define CCS_OFF_CTRL 12'h000
`define CCS_OFF_CNT_A 12'h004
`define CCS_OFF_CNT_B 12'h008
`define CCS_OFF_CNT_IR 12'h00C
`define CCS_OFF_IRQ_ST 12'h010
`define CCS_OFF_IRQ_MASK 12'h014

`define CCS_B_BAND 7
`define CCS_B_GAIN 6
`define CCS_B_REFOUT 5
`define CCS_B_STABLE 4
`define CCS_B_KIND 3
`define CCS_B_EN 2
`define CCS_B_START 1
`define CCS_B_SEL 0

`define CCS_IRQ_W 2
`define CCS_IRQ_DONE 0
`define CCS_IRQ_STABLE 1

`define CCS_CTRL_RST 8'h00
`define CCS_CTRL_RW_MASK 8'hED
`define CCS_CNT_ZERO 8'h00
`define CCS_CNT_ONE 8'h01
`define CCS_CNT_MAX 8'hFF
`define CCS_IRQ_ZERO 2'h0
`define CCS_DATA_ZERO 32'h0000_0000

`endif

// [include/ccs_pkg.sv]
// types shared by the clock check and select logic
package ccs_pkg;

   // measurement sequencer, one-hot
   typedef enum logic [1:0] {
      CCS_IDLE = 2'b01,
      CCS_RUN = 2'b10
   } ccs_state_t;

   typedef logic [7:0] ccs_count_t;

endpackage

// [logic/ccs_counter.sv]
// one activity counter fed by a sampled oscillator level
`timescale 1ns/1ps
`include "ccs_params.svh"

module ccs_counter
   import ccs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_src,
   input wire logic i_gate,
   input wire logic i_clear,
   input wire logic i_run,
   input wire logic i_stop,
   output ccs_count_t o_count,
   output logic o_sat
);

   logic src_s1_q;
   logic src_s2_q;
   logic src_prev_q;
   logic stop_s1_q;
   logic stop_s2_q;
   ccs_count_t count_q;
   logic edge_w;
   logic adv_w;

   // a rising edge of the source counts only while the gate is open
   assign edge_w = src_s2_q & ~src_prev_q & i_gate;
   assign o_sat = (count_q == `CCS_CNT_MAX);
   assign adv_w = edge_w & i_run & ~o_sat & ~stop_s2_q;
   assign o_count = count_q;

   // stop is resynchronised on the source's own edges, so it lags a little
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         src_s1_q <= 1'b0;
         src_s2_q <= 1'b0;
         src_prev_q <= 1'b0;
         stop_s1_q <= 1'b0;
         stop_s2_q <= 1'b0;
         count_q <= `CCS_CNT_ZERO;
      end else if (i_ce) begin
         src_s1_q <= i_src;
         src_s2_q <= src_s1_q;
         src_prev_q <= src_s2_q;
         if (i_clear) begin
            count_q <= `CCS_CNT_ZERO;
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
         end else if (edge_w) begin
            stop_s1_q <= i_stop;
            stop_s2_q <= stop_s1_q;
            if (adv_w) begin
               count_q <= count_q + `CCS_CNT_ONE;
            end
         end
      end
   end

endmodule

// [logic/ccs_top.sv]
// clock check and select: control register, check counters, clock steering
`timescale 1ns/1ps
`include "ccs_params.svh"

module ccs_top
   import ccs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`CCS_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_crystal_osc_a,
   input wire logic i_crystal_osc_b,
   input wire logic i_internal_ref_clk,
   input wire logic i_osc_a_stable,
   output logic o_osc_a_freq_band,
   output logic o_osc_a_high_gain,
   output logic o_osc_a_source_kind,
   output logic o_external_ref_clock_out,
   output logic o_clock_generator_ext_in,
   output logic o_time_of_day_clk,
   output logic o_irq
);

   // true when an address selects the given register word
   function automatic logic reg_hit(input logic [`CCS_ADDR_W-1:0] addr,
                                    input logic [`CCS_ADDR_W-1:0] off);
      reg_hit = (addr == off);
   endfunction

   ccs_state_t state_q;
   ccs_state_t state_d;
   logic [7:0] ctrl_q;
   logic clear_q;
   logic stable_prev_q;
   logic [`CCS_IRQ_W-1:0] irq_st_q;
   logic [`CCS_IRQ_W-1:0] irq_st_d;
   logic [`CCS_IRQ_W-1:0] irq_mask_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   ccs_count_t cnt_a;
   ccs_count_t cnt_b;
   ccs_count_t cnt_ir;
   logic sat_a;
   logic sat_b;
   logic sat_ir;

   // address decode
   logic hit_ctrl;
   logic hit_cnt_a;
   logic hit_cnt_b;
   logic hit_cnt_ir;
   logic hit_st;
   logic hit_mask;
   logic mapped;
   logic setup_w;
   logic access_w;
   logic wr_ctrl;
   logic wr_st;
   logic wr_mask;
   logic start_w;
   logic busy_w;
   logic any_sat;
   logic done_w;
   logic stable_rise;
   logic [7:0] ctrl_view;
   logic [7:0] rd_byte;
   logic [`CCS_IRQ_W-1:0] ev_w;
   logic [`CCS_IRQ_W-1:0] st_clr;

   assign hit_ctrl = reg_hit(i_paddr, `CCS_OFF_CTRL);
   assign hit_cnt_a = reg_hit(i_paddr, `CCS_OFF_CNT_A);
   assign hit_cnt_b = reg_hit(i_paddr, `CCS_OFF_CNT_B);
   assign hit_cnt_ir = reg_hit(i_paddr, `CCS_OFF_CNT_IR);
   assign hit_st = reg_hit(i_paddr, `CCS_OFF_IRQ_ST);
   assign hit_mask = reg_hit(i_paddr, `CCS_OFF_IRQ_MASK);
   assign mapped = hit_ctrl | hit_cnt_a | hit_cnt_b | hit_cnt_ir |
                   hit_st | hit_mask;
   assign setup_w = i_psel & ~i_penable;
   assign access_w = i_psel & i_penable;
   assign wr_ctrl = access_w & i_pwrite & hit_ctrl;
   assign wr_st = access_w & i_pwrite & hit_st;
   assign wr_mask = access_w & i_pwrite & hit_mask;

   // a one in the start bit restarts; a zero is ignored
   assign start_w = wr_ctrl & i_pwdata[`CCS_B_START];
   assign busy_w = (state_q == CCS_RUN);
   assign any_sat = sat_a | sat_b | sat_ir;
   // the counts of the previous run are ignored in the clearing cycle
   assign done_w = busy_w & any_sat & ~clear_q;
   assign stable_rise = i_osc_a_stable & ~stable_prev_q;

   // control as read: live stable flag and running status
   always_comb begin
      ctrl_view = ctrl_q;
      ctrl_view[`CCS_B_STABLE] = i_osc_a_stable;
      ctrl_view[`CCS_B_START] = busy_w;
   end

   // read data selection
   assign rd_byte = hit_ctrl ? ctrl_view :
                    hit_cnt_a ? cnt_a :
                    hit_cnt_b ? cnt_b :
                    hit_cnt_ir ? cnt_ir :
                    hit_st ? {6'h00, irq_st_q} :
                    hit_mask ? {6'h00, irq_mask_q} : `CCS_CNT_ZERO;

   // sticky events, a new event beats a simultaneous clear
   assign ev_w[`CCS_IRQ_DONE] = done_w;
   assign ev_w[`CCS_IRQ_STABLE] = stable_rise;
   assign st_clr = wr_st ? i_pwdata[`CCS_IRQ_W-1:0] : `CCS_IRQ_ZERO;
   assign irq_st_d = (irq_st_q & ~st_clr) | ev_w;

   // measurement sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         CCS_IDLE: begin
            if (start_w) begin
               state_d = CCS_RUN;
            end
         end
         CCS_RUN: begin
            if (start_w) begin
               state_d = CCS_RUN;
            end else if (done_w) begin
               state_d = CCS_IDLE;
            end
         end
         default: begin
            state_d = CCS_IDLE;
         end
      endcase
   end

   // control and sequencer registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         state_q <= CCS_IDLE;
         ctrl_q <= `CCS_CTRL_RST;
         clear_q <= 1'b0;
         stable_prev_q <= 1'b0;
      end else if (i_ce) begin
         state_q <= state_d;
         clear_q <= start_w;
         stable_prev_q <= i_osc_a_stable;
         if (wr_ctrl) begin
            ctrl_q <= i_pwdata[7:0] & `CCS_CTRL_RW_MASK;
         end
      end
   end

   // interrupt registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         irq_st_q <= `CCS_IRQ_ZERO;
         irq_mask_q <= `CCS_IRQ_ZERO;
      end else if (i_ce) begin
         irq_st_q <= irq_st_d;
         if (wr_mask) begin
            irq_mask_q <= i_pwdata[`CCS_IRQ_W-1:0];
         end
      end
   end

   // read data and error are captured in the setup cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         prdata_q <= `CCS_DATA_ZERO;
         pslverr_q <= 1'b0;
      end else if (i_ce && setup_w) begin
         prdata_q <= {24'h00_0000, rd_byte};
         pslverr_q <= ~mapped;
      end
   end

   assign o_prdata = prdata_q;
   assign o_pready = 1'b1;
   assign o_pslverr = pslverr_q & access_w;

   // oscillator configuration and steering
   assign o_osc_a_freq_band = ctrl_q[`CCS_B_BAND];
   assign o_osc_a_high_gain = ctrl_q[`CCS_B_GAIN];
   assign o_osc_a_source_kind = ctrl_q[`CCS_B_KIND];
   assign o_external_ref_clock_out = i_crystal_osc_a &
                                     ctrl_q[`CCS_B_REFOUT];
   assign o_clock_generator_ext_in = ctrl_q[`CCS_B_SEL] ?
                                     i_crystal_osc_a :
                                     i_crystal_osc_b;
   assign o_time_of_day_clk = i_crystal_osc_a;
   assign o_irq = |(irq_st_q & irq_mask_q);

   // first oscillator counter
   ccs_counter u_cnt_a (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_src(i_crystal_osc_a),
      .i_gate(ctrl_q[`CCS_B_EN]),
      .i_clear(clear_q),
      .i_run(busy_w),
      .i_stop(any_sat),
      .o_count(cnt_a),
      .o_sat(sat_a)
   );

   // second oscillator counter
   ccs_counter u_cnt_b (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_src(i_crystal_osc_b),
      .i_gate(ctrl_q[`CCS_B_EN]),
      .i_clear(clear_q),
      .i_run(busy_w),
      .i_stop(any_sat),
      .o_count(cnt_b),
      .o_sat(sat_b)
   );

   // internal reference counter
   ccs_counter u_cnt_ir (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_src(i_internal_ref_clk),
      .i_gate(ctrl_q[`CCS_B_EN]),
      .i_clear(clear_q),
      .i_run(busy_w),
      .i_stop(any_sat),
      .o_count(cnt_ir),
      .o_sat(sat_ir)
   );

   // a control write reaches the range and gain pins one cycle later
   cfg_pins_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_ce && wr_ctrl) |=>
      (o_osc_a_freq_band == $past(i_pwdata[`CCS_B_BAND]) &&
       o_osc_a_high_gain == $past(i_pwdata[`CCS_B_GAIN])))
      else $error("range or gain pin does not follow control write");

   // reference output stays low while its enable is clear
   refout_gate_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !ctrl_q[`CCS_B_REFOUT] |-> !o_external_ref_clock_out)
      else $error("reference output active while disabled");

   // steering picks the second oscillator when the select bit is low
   steer_mux_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      o_clock_generator_ext_in ==
      (ctrl_q[`CCS_B_SEL] ? i_crystal_osc_a : i_crystal_osc_b))
      else $error("generator input steered to wrong oscillator");

   // a start write zeroes all three counters two enabled cycles later
   start_clear_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_ce && start_w) ##1 i_ce |=>
      (cnt_a == `CCS_CNT_ZERO && cnt_b == `CCS_CNT_ZERO &&
       cnt_ir == `CCS_CNT_ZERO && busy_w))
      else $error("counters not cleared or run not started");

   // saturation ends the run on the next enabled edge
   sat_done_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_ce && done_w && !start_w) |=> (!busy_w && irq_st_q[`CCS_IRQ_DONE]))
      else $error("run not ended or done flag not set");

   // writing zero to the start bit never stops a run
   zero_write_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (busy_w && wr_ctrl && !i_pwdata[`CCS_B_START] && !done_w) |=> busy_w)
      else $error("start bit cleared by a zero write");

   // a closed gate holds the first counter still
   gate_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (!ctrl_q[`CCS_B_EN] && !clear_q) |=> (cnt_a == $past(cnt_a)))
      else $error("counter moved with inputs gated off");

   // an unmasked event raises the interrupt on the next enabled edge
   irq_level_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_ce && |(ev_w & irq_mask_q) && !wr_mask) |=> o_irq)
      else $error("unmasked event did not raise the interrupt");

   // an unmapped address answers with an error in the access cycle
   unmapped_err_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_ce && setup_w && !mapped) ##1 access_w |-> o_pslverr)
      else $error("unmapped access not flagged");

endmodule

// [testbench/tb_ccs_top.sv]
// self-checking bench for the clock check and select block
`timescale 1ns/1ps
`include "ccs_params.svh"

module tb_ccs_top
   import ccs_pkg::*;
;
   logic clk, rstn, psel, pen, pwr, osc_a, osc_b, irc, stable, er, ce;
   logic [`CCS_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, d, seed;
   logic pready, pslverr, band, gain, kind, refout, gen_in, time_of_day_block, irq;
   logic [7:0] cnt [3];
   int num_errors, compares, tick, n;

   ccs_top u_ccs_top (.i_sys_clk(clk), .i_resetn(rstn), .i_ce(ce),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_crystal_osc_a(osc_a),
      .i_crystal_osc_b(osc_b), .i_internal_ref_clk(irc),
      .i_osc_a_stable(stable), .o_osc_a_freq_band(band),
      .o_osc_a_high_gain(gain), .o_osc_a_source_kind(kind),
      .o_external_ref_clock_out(refout), .o_clock_generator_ext_in(gen_in),
      .o_time_of_day_clk(time_of_day_block), .o_irq(irq));

   // 40 MHz system clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // oscillator levels with half periods of 3, 4 and 5 cycles
   always @(posedge clk) begin
      tick <= tick + 1;
      if (tick % 3 == 2) osc_a <= ~osc_a;
      if (tick % 4 == 3) osc_b <= ~osc_b;
      if (tick % 5 == 4) irc <= ~irc;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // readback of control: bit1 reads busy, bit4 shows the live input
   function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
      return (w & 32'h0000_00ED) | {27'h0, stable, 4'h0};
   endfunction

   // expected count of a source when the half-3 oscillator saturates
   function automatic int near_cnt(input int half);
      return 255 * 3 / half;
   endfunction

   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task chk_near(input logic [31:0] g, input int e);
      compares++;
      if ((^g) === 1'bx || int'(g) > e + 5 || int'(g) + 5 < e) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // one apb transfer; read data and error land in rd and er
   task apb(input logic w, input logic [`CCS_ADDR_W-1:0] a,
            input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // poll the busy bit until the measurement ends
   task wait_done();
      n = 0;
      do begin
         apb(1'b0, `CCS_OFF_CTRL, 32'h0);
         n++;
      end while (rd[1] !== 1'b0 && n < 3000);
      chk(rd[1], 1'b0);
   endtask

   task results();
      $display("checks %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog against a hung handshake or a measurement that never ends
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      results();
   end

   initial begin
      {rstn, psel, pen, pwr, osc_a, osc_b, irc, stable} = 8'h00;
      ce = 1'b1;
      paddr = '0;
      pwdata = 32'h0;
      seed = 32'h0000_0031;
      tick = 0;
      num_errors = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      // reset values of all registers and of the configuration, reference, steering and irq outputs
      for (int a = 0; a < 6; a++) begin
         apb(1'b0, 12'(a * 4), 32'h0);
         chk(rd, 32'h0);
      end
      @(negedge clk);
      chk({band, gain, kind, refout, irq}, 5'h00);
      chk(gen_in, osc_b);
      $display("test reset done");
      // control fields: corners then random values, start bit kept 0
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'h0000_00FD : (i == 1) ? 32'h0 :
             xs() & 32'h0000_00FD;
         apb(1'b1, `CCS_OFF_CTRL, d);
         apb(1'b0, `CCS_OFF_CTRL, 32'h0);
         chk(rd, exp_ctrl(d));
         repeat (8) begin
            @(negedge clk);
            chk({band, gain, kind}, {d[7], d[6], d[3]});
            chk(refout, osc_a & d[5]);
            chk(gen_in, d[0] ? osc_a : osc_b);
            chk(time_of_day_block, osc_a);
         end
      end
      $display("test control done");
      // full measurement, with a write of 0 to start in mid-run
      apb(1'b1, `CCS_OFF_IRQ_ST, 32'h0000_0003);
      apb(1'b1, `CCS_OFF_CTRL, 32'h0000_0006);
      apb(1'b1, `CCS_OFF_CTRL, 32'h0000_0004);
      apb(1'b0, `CCS_OFF_CTRL, 32'h0);
      chk(rd[1], 1'b1);
      wait_done();
      for (int c = 0; c < 3; c++) begin
         apb(1'b0, 12'(4 + c * 4), 32'h0);
         cnt[c] = rd[7:0];
      end
      chk(cnt[0], `CCS_CNT_MAX);
      chk_near(cnt[1], near_cnt(4));
      chk_near(cnt[2], near_cnt(5));
      repeat (100) @(posedge clk);
      for (int c = 0; c < 3; c++) begin
         apb(1'b0, 12'(4 + c * 4), 32'h0);
         chk(rd, cnt[c]);
      end
      apb(1'b0, `CCS_OFF_IRQ_ST, 32'h0);
      chk(rd[0], 1'b1);
      $display("test measure done");
      // counting blocked: start runs but nothing counts
      apb(1'b1, `CCS_OFF_CTRL, 32'h0000_0002);
      repeat (200) @(posedge clk);
      apb(1'b0, `CCS_OFF_CTRL, 32'h0);
      chk(rd[1], 1'b1);
      for (int c = 0; c < 3; c++) begin
         apb(1'b0, 12'(4 + c * 4), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b1, `CCS_OFF_CTRL, 32'h0000_0006);
      wait_done();
      $display("test enable done");
      // clock enable low freezes a running measurement
      apb(1'b1, `CCS_OFF_IRQ_ST, 32'h0000_0001);
      apb(1'b1, `CCS_OFF_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, `CCS_OFF_CTRL, 32'h0000_0006);
      repeat (300) @(posedge clk);
      apb(1'b0, `CCS_OFF_CNT_A, 32'h0);
      d = rd;
      ce <= 1'b0;
      repeat (2000) @(posedge clk);
      ce <= 1'b1;
      apb(1'b0, `CCS_OFF_CNT_A, 32'h0);
      chk_near(rd, int'(d));
      apb(1'b0, `CCS_OFF_CTRL, 32'h0);
      chk(rd[1], 1'b1);
      @(negedge clk);
      chk(irq, 1'b0);
      wait_done();
      @(negedge clk);
      chk(irq, 1'b1);
      $display("test freeze done");
      // interrupts: stable edge event, mask, write one to clear
      apb(1'b1, `CCS_OFF_IRQ_ST, 32'h0000_0003);
      stable <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, `CCS_OFF_IRQ_ST, 32'h0);
      chk(rd, 32'h0000_0002);
      apb(1'b0, `CCS_OFF_CTRL, 32'h0);
      chk(rd[4], 1'b1);
      @(negedge clk);
      chk(irq, 1'b0);
      apb(1'b1, `CCS_OFF_IRQ_MASK, 32'h0000_0002);
      @(negedge clk);
      chk(irq, 1'b1);
      apb(1'b1, `CCS_OFF_IRQ_ST, 32'h0000_0001);
      @(negedge clk);
      chk(irq, 1'b1);
      apb(1'b1, `CCS_OFF_IRQ_ST, 32'h0000_0002);
      @(negedge clk);
      chk(irq, 1'b0);
      $display("test interrupt done");
      // unmapped address and read-only counts
      apb(1'b0, 12'h018, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      apb(1'b1, `CCS_OFF_CNT_A, 32'h0000_0055);
      chk(er, 1'b0);
      apb(1'b0, `CCS_OFF_CNT_A, 32'h0);
      chk(rd, 32'h0000_00FF);
      $display("test access done");
      results();
   end
endmodule
